// File: src/isa_host_pkg.sv
// Constants for the ISA host interface of the acquisition board.
// Assumes a single 100 MHz system clock and an active-low asynchronous reset.
package isa_host_pkg;
   localparam int          ADDR_W          = 10;
   localparam int          BASE_LSB        = 5;
   localparam int          BASE_W          = 5;
   localparam int          REG_SEL_W       = 5;
   localparam int          NUM_REGS        = 32;
   localparam int          DATA_W          = 16;
   localparam int          NUM_SRC         = 5;
   localparam int          SRC_DATA        = 0;
   localparam int          SRC_DONE        = 1;
   localparam int          SRC_TC          = 2;
   localparam int          SRC_CTR2        = 3;
   localparam int          SRC_ERR         = 4;
   localparam int          NUM_IRQ         = 11;
   localparam int          IRQ_SEL_W       = 4;
   localparam int          NUM_DMA         = 3;
   localparam int          DMA_SEL_W       = 2;
   localparam int          FIFO_DEPTH      = 512;
   localparam int          FIFO_CNT_W      = 10;
   localparam logic [15:0] IRQ_LINE_MAP    = 16'hDEF8;
   localparam logic [4:0]  RESET_ENABLES   = 5'h00;
   localparam logic [3:0]  RESET_IRQ_SEL   = 4'h0;
   localparam logic [1:0]  RESET_DMA_SEL   = 2'h0;
endpackage

// File: src/isa_host_interface.sv
// ISA I/O channel interface: address latch and decode, data buffer control,
// interrupt routing and DMA requests for the A/D FIFO.
// Assumes ISA strobes and pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module isa_host_interface
   import isa_host_pkg::*;
#(
   // Depth of the A/D FIFO that the overflow count watches.
   parameter int FIFO_LIMIT = isa_host_pkg::FIFO_DEPTH
)
(
   input  wire logic                                 clk_sys,
   input  wire logic                                 rst_n,
   input  wire logic [isa_host_pkg::ADDR_W-1:0]      bus_addr,
   input  wire logic                                 bus_aen,
   input  wire logic                                 bus_ior_n,
   input  wire logic                                 bus_iow_n,
   input  wire logic                                 bus_sbhe_n,
   input  wire logic [isa_host_pkg::BASE_W-1:0]      base_addr,
   input  wire logic [isa_host_pkg::NUM_REGS-1:0]    reg_is_wide,
   output logic [isa_host_pkg::NUM_REGS-1:0]         reg_select,
   output logic                                      reg_rd,
   output logic                                      reg_wr,
   output logic                                      reg_wide,
   output logic                                      data_to_host_oe_n,
   output logic                                      data_to_board_oe_n,
   output logic                                      board_accessed,
   output logic                                      bus_ready,
   output logic                                      bus_iocs16_n,
   input  wire logic                                 fifo_not_empty,
   input  wire logic                                 fifo_write,
   input  wire logic                                 fifo_read,
   input  wire logic                                 acq_done,
   input  wire logic                                 counter_output_two,
   input  wire logic                                 overrun_err,
   input  wire logic                                 bus_tc,
   input  wire logic                                 bus_dack_n,
   input  wire logic [isa_host_pkg::NUM_SRC-1:0]     irq_enable,
   input  wire logic [isa_host_pkg::NUM_SRC-1:0]     irq_clear,
   input  wire logic [isa_host_pkg::IRQ_SEL_W-1:0]   irq_line_sel,
   input  wire logic                                 dma_enable,
   input  wire logic                                 dma_dual_mode,
   input  wire logic [isa_host_pkg::DMA_SEL_W-1:0]   dma_chan_sel,
   input  wire logic [isa_host_pkg::DMA_SEL_W-1:0]   dma_chan2_sel,
   output logic [isa_host_pkg::NUM_SRC-1:0]          irq_flags,
   output logic                                      fifo_overflow,
   output logic [isa_host_pkg::NUM_IRQ-1:0]          irq_out,
   output logic [isa_host_pkg::NUM_IRQ-1:0]          irq_oe_n,
   output logic [isa_host_pkg::NUM_DMA-1:0]          dma_req
);
   import isa_host_pkg::*;

   typedef enum logic [1:0] {IDLE, READ, WRITE, DONE} cycle_t;

   // One-hot decode, used for register select and for channel selection.
   function automatic logic [NUM_REGS-1:0] one_hot(input logic [REG_SEL_W-1:0] idx);
      logic [NUM_REGS-1:0] v;
      v = '0;
      v[idx] = 1'b1;
      return v;
   endfunction

   // Two-flop synchronisers for every pin that arrives from the bus.
   // The address settles before a strobe falls, so it is synchronised alongside the strobes.
   logic [ADDR_W-1:0] addr_s1;
   logic [ADDR_W-1:0] addr_s2;
   logic [5:0]        ctl_s1;
   logic [5:0]        ctl_s2;
   logic              ior_n;
   logic              iow_n;
   logic              aen;
   logic              sbhe_n;
   logic              tc;
   logic              dack_n;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_s1 <= '0;
         addr_s2 <= '0;
         // Idle bus levels: strobes, byte enable and acknowledge high, AEN and TC low.
         ctl_s1  <= 6'h2B;
         ctl_s2  <= 6'h2B;
      end else begin
         addr_s1 <= bus_addr;
         addr_s2 <= addr_s1;
         ctl_s1  <= {bus_dack_n, bus_tc, bus_sbhe_n, bus_aen, bus_iow_n, bus_ior_n};
         ctl_s2  <= ctl_s1;
      end
   end

   assign ior_n  = ctl_s2[0];
   assign iow_n  = ctl_s2[1];
   assign aen    = ctl_s2[2];
   assign sbhe_n = ctl_s2[3];
   assign tc     = ctl_s2[4];
   assign dack_n = ctl_s2[5];

   // Address latch and transfer cycle.
   cycle_t            state;
   logic [ADDR_W-1:0] addr_latched;
   logic              hit;
   logic              start_rd;
   logic              start_wr;

   // DMA cycles drive AEN high, so they never match the I/O window.
   assign hit      = !aen && (addr_s2[ADDR_W-1:BASE_LSB] == base_addr);
   assign start_rd = hit && !ior_n;
   assign start_wr = hit && !iow_n;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state        <= IDLE;
         addr_latched <= '0;
      end else begin
         case (state)
            IDLE: begin
               if (start_rd || start_wr) begin
                  addr_latched <= addr_s2;
                  state        <= start_rd ? READ : WRITE;
               end
            end
            READ: begin
               if (ior_n) begin
                  state <= DONE;
               end
            end
            WRITE: begin
               if (iow_n) begin
                  state <= DONE;
               end
            end
            // DONE leaves one idle cycle, so back-to-back strobes stay separate transfers.
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

   // Register side strobes and buffer controls, all registered.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_select         <= '0;
         reg_rd             <= 1'b0;
         reg_wr             <= 1'b0;
         reg_wide           <= 1'b0;
         data_to_host_oe_n  <= 1'b1;
         data_to_board_oe_n <= 1'b1;
         board_accessed     <= 1'b0;
         bus_ready          <= 1'b1;
         bus_iocs16_n       <= 1'b1;
      end else begin
         reg_select         <= '0;
         reg_rd             <= 1'b0;
         reg_wr             <= 1'b0;
         data_to_host_oe_n  <= 1'b1;
         data_to_board_oe_n <= 1'b1;
         board_accessed     <= 1'b0;
         bus_ready          <= 1'b1;
         bus_iocs16_n       <= 1'b1;
         if (state == READ || state == WRITE) begin
            reg_select <= one_hot(addr_latched[REG_SEL_W-1:0]);
            reg_rd     <= (state == READ);
            reg_wr     <= (state == WRITE);
            // A wide transfer needs a 16-bit register and the host's high byte enable.
            reg_wide   <= reg_is_wide[addr_latched[REG_SEL_W-1:0]] && !sbhe_n;
            data_to_host_oe_n  <= (state != READ);
            data_to_board_oe_n <= (state != WRITE);
            board_accessed     <= 1'b1;
            bus_iocs16_n       <= !reg_is_wide[addr_latched[REG_SEL_W-1:0]];
         end
         // Ready drops for the first cycle only, so the register strobe settles.
         if (state == IDLE && (start_rd || start_wr)) begin
            bus_ready <= 1'b0;
         end
      end
   end

   // Counter output two: synchronise, then pulse on the rising edge.
   // A third flop keeps the previous level, so the edge is taken from settled values only.
   logic       ctr_s1;
   logic       ctr_s2;
   logic       ctr_s3;
   logic       ctr_rise;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctr_s1 <= 1'b0;
         ctr_s2 <= 1'b0;
         ctr_s3 <= 1'b0;
      end else begin
         ctr_s1 <= counter_output_two;
         ctr_s2 <= ctr_s1;
         ctr_s3 <= ctr_s2;
      end
   end

   assign ctr_rise = ctr_s2 && !ctr_s3;

   // FIFO occupancy, kept here to detect unread results beyond the depth.
   logic [FIFO_CNT_W-1:0] fifo_count;
   logic                  fifo_at_limit;
   logic                  overflow_event;

   // The count stops at the limit, so every further unread write is a lost result.
   assign fifo_at_limit  = (fifo_count == FIFO_CNT_W'(FIFO_LIMIT));
   assign overflow_event = fifo_write && !fifo_read && fifo_at_limit;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fifo_count    <= '0;
         fifo_overflow <= 1'b0;
      end else begin
         // A read and a write in the same cycle leave the occupancy as it is.
         if (fifo_write && !fifo_read && !fifo_at_limit) begin
            fifo_count <= fifo_count + 1'b1;
         end else if (fifo_read && !fifo_write && fifo_count != '0) begin
            fifo_count <= fifo_count - 1'b1;
         end
         if (overflow_event) begin
            fifo_overflow <= 1'b1;
         end else if (irq_clear[SRC_ERR]) begin
            fifo_overflow <= 1'b0;
         end
      end
   end

   // Sticky interrupt flags; a new event beats a clear in the same cycle.
   logic [NUM_SRC-1:0] events;

   always_comb begin
      events           = '0;
      events[SRC_DATA] = fifo_not_empty;
      events[SRC_DONE] = acq_done;
      events[SRC_TC]   = tc && !dack_n;
      events[SRC_CTR2] = ctr_rise;
      events[SRC_ERR]  = overrun_err || overflow_event;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_flags <= '0;
      end else begin
         irq_flags <= events | (irq_flags & ~irq_clear);
      end
   end

   // Interrupt routing onto one of the eleven host lines, driven only when asserted.
   // Line index 0 to 10 stands for IRQ3 to IRQ7, IRQ9 to IRQ12, IRQ14 and IRQ15.
   logic                   any_irq;
   logic [NUM_IRQ-1:0]     line_hit;
   logic [IRQ_SEL_W-1:0]   irq_sel_cur;

   assign any_irq     = |(irq_flags & irq_enable & ~irq_clear);
   assign irq_sel_cur = (irq_line_sel < IRQ_SEL_W'(NUM_IRQ)) ? irq_line_sel : RESET_IRQ_SEL;

   always_comb begin
      line_hit = '0;
      for (int i = 0; i < NUM_IRQ; i++) begin
         line_hit[i] = (IRQ_SEL_W'(i) == irq_sel_cur);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_out  <= '0;
         irq_oe_n <= '1;
      end else begin
         irq_out  <= line_hit & {NUM_IRQ{any_irq}};
         // The line is released rather than driven low, so it can be shared.
         irq_oe_n <= ~(line_hit & {NUM_IRQ{any_irq}});
      end
   end

   // DMA requests; dual mode alternates between the two chosen channels.
   logic                dma_phase;
   logic                tc_ack;
   logic                tc_ack_prev;
   logic [NUM_REGS-1:0] dma_hot;

   // TC stands for a whole bus cycle, so only its first cycle may switch the channel.
   assign tc_ack  = !dack_n && tc;
   assign dma_hot = one_hot(REG_SEL_W'(dma_phase ? dma_chan2_sel : dma_chan_sel));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tc_ack_prev <= 1'b0;
      end else begin
         tc_ack_prev <= tc_ack;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dma_phase <= 1'b0;
      end else if (!dma_dual_mode) begin
         dma_phase <= 1'b0;
      end else if (tc_ack && !tc_ack_prev) begin
         dma_phase <= !dma_phase;
      end
   end

   // Channel code 3 names no channel and so raises no request.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dma_req <= '0;
      end else begin
         dma_req <= '0;
         if (dma_enable && fifo_not_empty) begin
            dma_req <= dma_hot[NUM_DMA-1:0];
         end
      end
   end

   // The occupancy counter must hold the full depth, and the line map has sixteen slots.
   if (FIFO_LIMIT < 1 || FIFO_LIMIT >= (1 << FIFO_CNT_W) || NUM_IRQ > 16) begin
      $error("isa_host_interface: unsupported parameter values");
   end
endmodule
`default_nettype wire

// File: bench/isa_host_chk.sv
// Port checker for the ISA host interface: decode, buffers, interrupts and DMA.
// Assumes the package is compiled first; bound to the design below.
`timescale 1ns/1ps
`default_nettype none
module isa_host_chk
   import isa_host_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [9:0]  bus_addr,
   input wire logic        bus_aen,
   input wire logic        bus_ior_n,
   input wire logic [4:0]  base_addr,
   input wire logic [31:0] reg_select,
   input wire logic        reg_rd,
   input wire logic        reg_wr,
   input wire logic        reg_wide,
   input wire logic        data_to_host_oe_n,
   input wire logic        board_accessed,
   input wire logic        bus_iocs16_n,
   input wire logic        bus_ready,
   input wire logic        fifo_not_empty,
   input wire logic [4:0]  irq_clear,
   input wire logic        dma_enable,
   input wire logic [4:0]  irq_flags,
   input wire logic [10:0] irq_oe_n,
   input wire logic [2:0]  dma_req
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sel_onehot_a: assert property ($onehot0(reg_select))
      else $error("more than one register select");
   read_dir_a: assert property (reg_rd |-> !data_to_host_oe_n)
      else $error("read without host buffer enable");
   strobe_excl_a: assert property (!(reg_rd && reg_wr))
      else $error("read and write strobes together");
   access_sel_a: assert property ((reg_rd || reg_wr) |-> board_accessed && |reg_select)
      else $error("transfer without access flag or select");
   wide_ack_a: assert property (reg_wide |-> !bus_iocs16_n)
      else $error("wide transfer without width signal");
   ready_pulse_a: assert property ($rose(board_accessed) |-> !$past(bus_ready) && bus_ready)
      else $error("ready not dropped for one cycle at transfer start");
   irq_share_a: assert property ($countones(~irq_oe_n) <= 1)
      else $error("more than one interrupt line driven");
   flag_hold_a: assert property ((($past(irq_flags) & ~$past(irq_clear)) & ~irq_flags) == 5'h00)
      else $error("interrupt flag dropped without clear");
   dma_gate_a: assert property (!dma_enable |=> dma_req == 3'h0)
      else $error("DMA request while disabled");
   dma_req_a: assert property ((fifo_not_empty && dma_enable) [*3] |-> $onehot(dma_req))
      else $error("no single DMA request with data present");
   take_read_a: assert property ($fell(bus_ior_n) && !bus_aen && bus_addr[9:5] == base_addr |-> ##[2:6] reg_rd)
      else $error("decoded read not taken");
endmodule
bind isa_host_interface isa_host_chk i_isa_host_chk (
   .clk_sys, .rst_n, .bus_addr, .bus_aen, .bus_ior_n, .base_addr, .reg_select, .reg_rd,
   .reg_wr, .reg_wide, .data_to_host_oe_n, .board_accessed, .bus_iocs16_n, .fifo_not_empty,
   .irq_clear, .dma_enable, .irq_flags, .irq_oe_n, .dma_req, .bus_ready
);
`default_nettype wire

// File: bench/isa_host_model.sv
// Host processor and DMA controller model that drives the ISA strobes.
// Assumes the bench calls its tasks and checks the design outputs itself.
`timescale 1ns/1ps
`default_nettype none
module isa_host_model (
   input  wire logic clk_sys,
   input  wire logic board_accessed,
   output logic [9:0] bus_addr,
   output logic       bus_aen,
   output logic       bus_ior_n,
   output logic       bus_iow_n,
   output logic       bus_sbhe_n,
   output logic       bus_tc,
   output logic       bus_dack_n
);
   initial begin
      bus_addr = 10'h000;
      bus_aen = 1'b0;
      bus_ior_n = 1'b1;
      bus_iow_n = 1'b1;
      bus_sbhe_n = 1'b1;
      bus_tc = 1'b0;
      bus_dack_n = 1'b1;
   end
   // The strobe stays low until the board answers, so the caller can look at the outputs.
   task automatic io_start(input logic [9:0] a, input logic rd, input logic hb, output logic ok);
      int n;
      n = 0;
      @(posedge clk_sys);
      bus_addr <= a;
      bus_sbhe_n <= ~hb;
      bus_ior_n <= ~rd;
      bus_iow_n <= rd;
      while (board_accessed !== 1'b1 && n < 12) begin
         @(posedge clk_sys);
         n++;
      end
      ok = board_accessed;
   endtask
   // A released address is inverted so that a stale value is never mistaken for a held one.
   task automatic io_end();
      @(posedge clk_sys);
      bus_ior_n <= 1'b1;
      bus_iow_n <= 1'b1;
      bus_sbhe_n <= 1'b1;
      bus_addr <= ~bus_addr;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic dma_ack(input logic tc);
      @(posedge clk_sys);
      bus_aen <= 1'b1;
      bus_dack_n <= 1'b0;
      bus_tc <= tc;
      repeat (4) @(posedge clk_sys);
      bus_aen <= 1'b0;
      bus_dack_n <= 1'b1;
      bus_tc <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// File: bench/isa_host_interface_tb.sv
// Bench for the ISA host interface: host cycles, interrupts, overflow and DMA.
// Assumes the package, design, host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module isa_host_interface_tb;
   import isa_host_pkg::*;
   logic        clk_sys = 1'b0, rst_n = 1'b0, fifo_write = 1'b0, fifo_read = 1'b0, ok;
   logic        dma_enable = 1'b0, dma_dual_mode = 1'b0;
   logic [4:0]  base_addr = 5'h0A, irq_enable = 5'h00, irq_clear = 5'h00, ev = 5'h00;
   logic [3:0]  irq_line_sel = 4'h0;
   logic [1:0]  dma_chan_sel = 2'h0, dma_chan2_sel = 2'h0;
   logic [4:0]  regs [3] = '{5'h00, 5'h11, 5'h1F};
   logic [9:0]  bus_addr;
   logic        bus_aen, bus_ior_n, bus_iow_n, bus_sbhe_n, bus_tc, bus_dack_n;
   logic [31:0] reg_select;
   logic        reg_rd, reg_wr, reg_wide, data_to_host_oe_n, data_to_board_oe_n;
   logic        board_accessed, bus_ready, bus_iocs16_n, fifo_overflow;
   logic [4:0]  irq_flags;
   logic [10:0] irq_out, irq_oe_n, line_exp;
   logic [2:0]  dma_req;
   int          n_mismatch = 0, cmp_count = 0, cycles = 0;
   always #5 clk_sys = ~clk_sys;
   isa_host_model i_isa_host_model (.clk_sys, .board_accessed, .bus_addr, .bus_aen, .bus_ior_n,
      .bus_iow_n, .bus_sbhe_n, .bus_tc, .bus_dack_n);
   isa_host_interface i_isa_host_interface (.clk_sys, .rst_n, .bus_addr, .bus_aen, .bus_ior_n,
      .bus_iow_n, .bus_sbhe_n, .base_addr, .reg_is_wide(32'h8000_0000), .reg_select, .reg_rd,
      .reg_wr, .reg_wide, .data_to_host_oe_n, .data_to_board_oe_n, .board_accessed, .bus_ready,
      .bus_iocs16_n, .fifo_not_empty(ev[0]), .fifo_write, .fifo_read, .acq_done(ev[1]),
      .counter_output_two(ev[3]), .overrun_err(ev[4]), .bus_tc, .bus_dack_n, .irq_enable,
      .irq_clear, .irq_line_sel, .dma_enable, .dma_dual_mode, .dma_chan_sel, .dma_chan2_sel,
      .irq_flags, .fifo_overflow, .irq_out, .irq_oe_n, .dma_req);
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic finish_test();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      cyc(5);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chk("idle outputs", 32'h7FF, irq_oe_n);
      foreach (regs[i]) begin
         for (int j = 0; j < 2; j++) begin
            i_isa_host_model.io_start({5'h0A, regs[i]}, j == 0, 1'b1, ok);
            @(negedge clk_sys);
            chk("select", 32'h1 << regs[i], reg_select);
            chk("accessed", 1'b1, ok);
            chk("rd wr", j == 0 ? 2'b10 : 2'b01, {reg_rd, reg_wr});
            chk("buffer oe_n", j == 0 ? 2'b01 : 2'b10, {data_to_host_oe_n, data_to_board_oe_n});
            chk("width", regs[i] == 5'h1F ? 2'b10 : 2'b01, {reg_wide, bus_iocs16_n});
            i_isa_host_model.io_end();
         end
      end
      base_addr <= 5'h1F;
      i_isa_host_model.io_start(10'h3FF, 1'b1, 1'b0, ok);
      @(negedge clk_sys);
      chk("top select", 32'h8000_0000, reg_select);
      chk("narrow", 2'b00, {reg_wide, bus_iocs16_n});
      i_isa_host_model.io_end();
      i_isa_host_model.io_start(10'h1FF, 1'b1, 1'b1, ok);
      @(negedge clk_sys);
      chk("miss", 1'b0, ok);
      chk("miss select", 32'h0, reg_select);
      i_isa_host_model.io_end();
      $display("Test host cycles done");
      // Pass 0 leaves the source disabled; pass 11 is out of range and falls back to line 0.
      for (int s = 0; s < 12; s++) begin
         irq_enable <= {3'h0, s != 0, 1'b1};
         irq_line_sel <= s[3:0];
         line_exp = s == 0 ? 11'h000 : (s == 11 ? 11'h001 : 11'h001 << s);
         ev[1] <= 1'b1;
         cyc(1);
         ev[1] <= 1'b0;
         cyc(5);
         @(negedge clk_sys);
         chk("irq line", line_exp, irq_out);
         chk("irq drive", {21'h0, ~line_exp}, irq_oe_n);
         chk("irq flags", 32'h2, irq_flags);
         cyc(1);
         irq_clear <= 5'h02;
         cyc(1);
         irq_clear <= 5'h00;
         cyc(4);
      end
      $display("Test interrupt lines done");
      irq_enable <= 5'h1F;
      for (int s = 0; s < 5; s++) begin
         if (s == 2) begin
            i_isa_host_model.dma_ack(1'b1);
         end else begin
            ev[s] <= 1'b1;
            cyc(1);
            ev[s] <= (s == 3);
         end
         cyc(5);
         @(negedge clk_sys);
         chk("flag set", 32'h1 << s, irq_flags);
         cyc(1);
         irq_clear[s] <= 1'b1;
         cyc(1);
         irq_clear <= 5'h00;
         cyc(5);
         @(negedge clk_sys);
         chk("flag clear", 32'h0, irq_flags);
         cyc(1);
      end
      ev[3] <= 1'b0;
      $display("Test sources done");
      fifo_write <= 1'b1;
      cyc(512);
      fifo_write <= 1'b0;
      fifo_read <= 1'b1;
      cyc(1);
      fifo_read <= 1'b0;
      fifo_write <= 1'b1;
      cyc(1);
      fifo_write <= 1'b0;
      cyc(3);
      @(negedge clk_sys);
      chk("full", 1'b0, fifo_overflow);
      cyc(1);
      fifo_write <= 1'b1;
      cyc(1);
      fifo_write <= 1'b0;
      cyc(3);
      @(negedge clk_sys);
      chk("overflow", 1'b1, fifo_overflow);
      $display("Test overflow done");
      dma_enable <= 1'b1;
      ev[0] <= 1'b1;
      dma_chan2_sel <= 2'h2;
      for (int c = 0; c < 4; c++) begin
         dma_chan_sel <= c == 3 ? 2'h0 : c[1:0];
         dma_dual_mode <= c == 3;
         cyc(4);
         @(negedge clk_sys);
         chk("dma channel", c == 3 ? 32'h1 : 32'h1 << c, dma_req);
         cyc(1);
      end
      i_isa_host_model.dma_ack(1'b1);
      @(negedge clk_sys);
      chk("dual second", 32'h4, dma_req);
      i_isa_host_model.dma_ack(1'b1);
      @(negedge clk_sys);
      chk("dual back", 32'h1, dma_req);
      cyc(1);
      dma_enable <= 1'b0;
      cyc(3);
      @(negedge clk_sys);
      chk("dma off", 32'h0, dma_req);
      $display("Test dma done");
      finish_test();
   end
endmodule
`default_nettype wire
